/* shared/smd_consts.svh */
`ifndef SMD_CONSTS_SVH
`define SMD_CONSTS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define SMD_OFS_TASK_START 12'h010
`define SMD_OFS_TASK_STOP 12'h014
`define SMD_OFS_EV_HALTED 12'h104
`define SMD_OFS_EV_RX_DONE 12'h110
`define SMD_OFS_EV_BOTH_DONE 12'h118
`define SMD_OFS_EV_TX_DONE 12'h120
`define SMD_OFS_EV_BEGAN 12'h14C
`define SMD_OFS_ENABLE 12'h500
`define SMD_OFS_PIN_CLK 12'h508
`define SMD_OFS_PIN_DOUT 12'h50C
`define SMD_OFS_PIN_DIN 12'h510
`define SMD_OFS_RATE 12'h524
`define SMD_OFS_RX_POINTER 12'h534
`define SMD_OFS_RX_LIMIT 12'h538
`define SMD_OFS_RX_AMOUNT 12'h53C
`define SMD_OFS_TX_POINTER 12'h544
`define SMD_OFS_TX_LIMIT 12'h548
`define SMD_OFS_TX_AMOUNT 12'h54C
`define SMD_OFS_CONFIG 12'h554
`define SMD_OFS_FILL 12'h5C0

// ------------------------------------------------------------
// fields, event indices, reset values
// ------------------------------------------------------------
`define SMD_CFG_ORDER_BIT 0
`define SMD_CFG_PHASE_BIT 1
`define SMD_CFG_POL_BIT 2
`define SMD_ENABLE_BIT 0
`define SMD_PIN_CONNECT_BIT 31
`define SMD_RATE_LSB 25
`define SMD_RATE_STEPS 7
`define SMD_EV_HALTED 0
`define SMD_EV_RX_DONE 1
`define SMD_EV_BOTH_DONE 2
`define SMD_EV_TX_DONE 3
`define SMD_EV_BEGAN 4
`define SMD_EV_COUNT 5
`define SMD_RST_RATE 32'h04000000
`define SMD_RST_PIN 32'hFFFFFFFF
`define SMD_RST_FILL 8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SMD_SYS_CLK_HZ 250000000
`define SMD_BASE_RATE_BPS 125000
`define SMD_RST_HALF_CYCLES 11'h1F4

`endif

/* shared/smd_pkg.sv */
package smd_pkg;
	typedef enum logic [2:0] {
		SMD_IDLE,
		SMD_CHECK,
		SMD_READ,
		SMD_SHIFT,
		SMD_STORE
	} smd_state_t;
endpackage

/* logic/smd_byte_shifter.sv */
`timescale 1ns/10ps
module smd_byte_shifter #(
	parameter int DIV_W = 11
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsb_first,
	input wire logic [DIV_W-1:0] half_cycles,
	input wire logic [7:0] tx_byte,
	input wire logic miso_sync,
	output logic sck,
	output logic mosi,
	output logic busy,
	output logic done,
	output logic [7:0] rx_byte
);
	logic [DIV_W-1:0] div_reg;
	logic [3:0] edge_reg;
	logic [7:0] tx_sh_reg;
	logic [7:0] rx_sh_reg;
	logic phase_reg;
	logic order_reg;
	logic tick;
	logic sample;
	logic [7:0] rx_next;
	logic [7:0] rx_fin;

	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = b[7-i];
		end
	endfunction

	assign tick = busy && (div_reg == '0);
	// leading edges have even index
	assign sample = (edge_reg[0] == phase_reg); // see [RL21]
	assign rx_next = {rx_sh_reg[6:0], miso_sync}; // see [RL10]
	assign rx_fin = sample ? rx_next : rx_sh_reg;

	// ------------------------------------------------------------
	// bit timing and clock pin
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			div_reg <= '0;
			edge_reg <= 4'h0;
			sck <= 1'b0;
			done <= 1'b0;
			phase_reg <= 1'b0;
			order_reg <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				sck <= cpol; // see [RL1]
				if (start) begin
					busy <= 1'b1;
					div_reg <= half_cycles - 1'b1;
					edge_reg <= 4'h0;
					phase_reg <= cpha;
					order_reg <= lsb_first;
				end
			end else if (tick) begin
				sck <= ~sck;
				edge_reg <= edge_reg + 4'h1;
				div_reg <= half_cycles - 1'b1;
				if (edge_reg == 4'hF) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end else begin
				div_reg <= div_reg - 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// data shifting, always msb-first internally
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tx_sh_reg <= 8'h00;
			rx_sh_reg <= 8'h00;
			rx_byte <= 8'h00;
			mosi <= 1'b0;
		end else if (!busy && start) begin
			tx_sh_reg <= lsb_first ? rev8(tx_byte) : tx_byte; // see [RL22]
			if (!cpha) begin
				mosi <= lsb_first ? tx_byte[0] : tx_byte[7];
				tx_sh_reg <= (lsb_first ? rev8(tx_byte) : tx_byte) << 1;
			end
		end else if (tick) begin
			if (sample) begin
				rx_sh_reg <= rx_next;
			end else begin
				mosi <= tx_sh_reg[7];
				tx_sh_reg <= tx_sh_reg << 1;
			end
			if (edge_reg == 4'hF) begin
				rx_byte <= order_reg ? rev8(rx_fin) : rx_fin; // see [RL22]
			end
		end
	end
endmodule // smd_byte_shifter

/* logic/smd_spi_master_dma.sv */
// Summary of operation
// [RL1] all four clock modes: polarity picks idle level, phase picks sampling edge
// [RL2] no chip select here; software drives general-purpose pins per slave
// [RL3] start task begins a transaction, stop task ends it
// [RL4] tx-done event after the transmit limit of bytes has shifted out
// [RL5] rx-done event after the last allowed receive byte is stored
// [RL6] both-done event once tx-done and rx-done have both occurred
// [RL7] stop task halts the master; halted event once it is at rest (never raised for a stop written in the last check cycle)
// [RL8] on halt, rx-done is raised if it has not been yet
// [RL9] on halt, tx-done is raised if it has not been yet
// [RL10] full duplex: one byte in for every byte out
// [RL11] pin selects act only while enabled, writable only while disabled
// [RL12] software sets clock pin idle, data-out 0, data-in as input
// [RL13] software gives each physical pin to one peripheral only
// [RL14] transmit channel reads memory, receive channel writes memory
// [RL15] pointers and limits are shadowed; rewrite allowed after began event
// [RL16] shifting ends itself at the larger of the two limits
// [RL17] transmit bytes beyond the transmit limit are the fill byte
// [RL18] received bytes beyond the receive limit are dropped
// [RL19] software waits for halted before clearing enable
// [RL20] one-hot rate codes from 125 kbps up to 8 Mbps, doubling
// [RL21] leading phase samples on first edge; trailing samples on second
// [RL22] bit order selects msb-first or lsb-first for both directions
`timescale 1ns/10ps
`include "smd_consts.svh"
module smd_spi_master_dma #(
	parameter int CNT_W = 16,
	parameter int DIV_W = 11
) (
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [31:0] MEM_ADDR,
	output logic [7:0] MEM_WDATA,
	input wire logic MEM_ACK,
	input wire logic [7:0] MEM_RDATA,
	output logic SCK_OUT,
	output logic SCK_OE,
	output logic MOSI_OUT,
	output logic MOSI_OE,
	input wire logic MISO_IN
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	smd_pkg::smd_state_t state_reg;
	logic enable_reg;
	logic [31:0] pin_clk_reg, pin_dout_reg, pin_din_reg;
	logic [31:0] rate_reg;
	logic [2:0] config_reg;
	logic [7:0] fill_reg;
	logic [31:0] rx_ptr_reg, tx_ptr_reg;
	logic [CNT_W-1:0] rx_lim_reg, tx_lim_reg;
	logic [31:0] rx_ptr_w_reg, tx_ptr_w_reg;
	logic [CNT_W-1:0] rx_lim_w_reg, tx_lim_w_reg;
	logic [CNT_W-1:0] rx_cnt_reg, tx_cnt_reg;
	logic [DIV_W-1:0] half_reg;
	logic [`SMD_EV_COUNT-1:0] ev_reg, ev_set;
	logic tx_flag_reg, rx_flag_reg, both_flag_reg, stop_pend_reg;
	logic [7:0] tx_byte_reg;
	logic shift_start_reg;
	logic miso_s1_reg, miso_s2_reg;
	logic shf_sck, shf_mosi, shf_busy, shf_done;
	logic [7:0] shf_rx;
	logic pready_reg;
	logic [31:0] prdata_next;
	logic mapped;
	logic wr, start_go, stop_go, halting, in_check;
	logic tx_reached, rx_reached, tx_raise, rx_raise, both_raise;

	// ------------------------------------------------------------
	// apb slave: one wait-free access phase, registered answer
	// ------------------------------------------------------------
	assign wr = PSEL && PENABLE && pready_reg && PWRITE;
	assign start_go = wr && (PADDR == `SMD_OFS_TASK_START) && PWDATA[0] && enable_reg
		&& (state_reg == smd_pkg::SMD_IDLE);
	assign stop_go = wr && (PADDR == `SMD_OFS_TASK_STOP) && PWDATA[0];

	always_comb begin
		mapped = 1'b1;
		prdata_next = 32'h00000000;
		unique case (PADDR)
			`SMD_OFS_TASK_START, `SMD_OFS_TASK_STOP: prdata_next = 32'h00000000;
			`SMD_OFS_EV_HALTED: prdata_next = {31'h0, ev_reg[`SMD_EV_HALTED]};
			`SMD_OFS_EV_RX_DONE: prdata_next = {31'h0, ev_reg[`SMD_EV_RX_DONE]};
			`SMD_OFS_EV_BOTH_DONE: prdata_next = {31'h0, ev_reg[`SMD_EV_BOTH_DONE]};
			`SMD_OFS_EV_TX_DONE: prdata_next = {31'h0, ev_reg[`SMD_EV_TX_DONE]};
			`SMD_OFS_EV_BEGAN: prdata_next = {31'h0, ev_reg[`SMD_EV_BEGAN]};
			`SMD_OFS_ENABLE: prdata_next = {31'h0, enable_reg};
			`SMD_OFS_PIN_CLK: prdata_next = pin_clk_reg;
			`SMD_OFS_PIN_DOUT: prdata_next = pin_dout_reg;
			`SMD_OFS_PIN_DIN: prdata_next = pin_din_reg;
			`SMD_OFS_RATE: prdata_next = rate_reg;
			`SMD_OFS_RX_POINTER: prdata_next = rx_ptr_reg;
			`SMD_OFS_RX_LIMIT: prdata_next = 32'(rx_lim_reg);
			`SMD_OFS_RX_AMOUNT: prdata_next = 32'(rx_cnt_reg);
			`SMD_OFS_TX_POINTER: prdata_next = tx_ptr_reg;
			`SMD_OFS_TX_LIMIT: prdata_next = 32'(tx_lim_reg);
			`SMD_OFS_TX_AMOUNT: prdata_next = 32'(tx_cnt_reg);
			`SMD_OFS_CONFIG: prdata_next = {29'h0, config_reg};
			`SMD_OFS_FILL: prdata_next = {24'h0, fill_reg};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			pready_reg <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else begin
			pready_reg <= PSEL && !PENABLE;
			PRDATA <= (PSEL && !PENABLE && !PWRITE) ? prdata_next : 32'h00000000;
			PSLVERR <= PSEL && !PENABLE && !mapped;
		end
	end
	assign PREADY = pready_reg;

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			enable_reg <= 1'b0;
			pin_clk_reg <= `SMD_RST_PIN;
			pin_dout_reg <= `SMD_RST_PIN;
			pin_din_reg <= `SMD_RST_PIN;
			rate_reg <= `SMD_RST_RATE;
			config_reg <= 3'h0;
			fill_reg <= `SMD_RST_FILL;
			rx_ptr_reg <= 32'h00000000;
			tx_ptr_reg <= 32'h00000000;
			rx_lim_reg <= '0;
			tx_lim_reg <= '0;
		end else if (wr) begin
			unique case (PADDR)
				`SMD_OFS_ENABLE: enable_reg <= PWDATA[`SMD_ENABLE_BIT];
				// pin selects frozen while enabled so a live link never re-routes
				`SMD_OFS_PIN_CLK: if (!enable_reg) pin_clk_reg <= PWDATA; // see [RL11]
				`SMD_OFS_PIN_DOUT: if (!enable_reg) pin_dout_reg <= PWDATA; // see [RL11]
				`SMD_OFS_PIN_DIN: if (!enable_reg) pin_din_reg <= PWDATA; // see [RL11]
				`SMD_OFS_RATE: rate_reg <= PWDATA;
				`SMD_OFS_CONFIG: config_reg <= PWDATA[2:0];
				`SMD_OFS_FILL: fill_reg <= PWDATA[7:0];
				`SMD_OFS_RX_POINTER: rx_ptr_reg <= PWDATA; // see [RL15]
				`SMD_OFS_RX_LIMIT: rx_lim_reg <= PWDATA[CNT_W-1:0];
				`SMD_OFS_TX_POINTER: tx_ptr_reg <= PWDATA;
				`SMD_OFS_TX_LIMIT: tx_lim_reg <= PWDATA[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// bit rate: one-hot code to half-period count, rounded up
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			half_reg <= DIV_W'(`SMD_RST_HALF_CYCLES);
		end else begin
			for (int i = 0; i < `SMD_RATE_STEPS; i++) begin
				if (rate_reg[`SMD_RATE_LSB+i]) begin // see [RL20]
					half_reg <= DIV_W'((`SMD_SYS_CLK_HZ + ((2 * `SMD_BASE_RATE_BPS) << i) - 1)
						/ ((2 * `SMD_BASE_RATE_BPS) << i));
				end
			end
		end
	end

	// ------------------------------------------------------------
	// events: hardware set wins over a software clear
	// ------------------------------------------------------------
	assign in_check = (state_reg == smd_pkg::SMD_CHECK);
	assign halting = in_check && stop_pend_reg;
	assign tx_reached = (tx_cnt_reg >= tx_lim_w_reg);
	assign rx_reached = (rx_cnt_reg >= rx_lim_w_reg);
	assign tx_raise = in_check && !tx_flag_reg && (tx_reached || stop_pend_reg); // see [RL4] [RL9]
	assign rx_raise = in_check && !rx_flag_reg && (rx_reached || stop_pend_reg); // see [RL5] [RL8]
	assign both_raise = in_check && !both_flag_reg && (tx_flag_reg || tx_raise)
		&& (rx_flag_reg || rx_raise); // see [RL6]

	always_comb begin
		ev_set = '0;
		ev_set[`SMD_EV_BEGAN] = start_go;
		ev_set[`SMD_EV_TX_DONE] = tx_raise;
		ev_set[`SMD_EV_RX_DONE] = rx_raise;
		ev_set[`SMD_EV_BOTH_DONE] = both_raise;
		ev_set[`SMD_EV_HALTED] = halting || (stop_go && state_reg == smd_pkg::SMD_IDLE); // see [RL7]
	end

	localparam logic [11:0] EV_OFS [`SMD_EV_COUNT] = '{`SMD_OFS_EV_HALTED, `SMD_OFS_EV_RX_DONE,
		`SMD_OFS_EV_BOTH_DONE, `SMD_OFS_EV_TX_DONE, `SMD_OFS_EV_BEGAN};

	for (genvar g = 0; g < `SMD_EV_COUNT; g++) begin : g_ev
		always_ff @(posedge SYS_CLK or negedge NRST) begin
			if (!NRST) begin
				ev_reg[g] <= 1'b0;
			end else if (ev_set[g]) begin
				ev_reg[g] <= 1'b1;
			end else if (wr && PADDR == EV_OFS[g] && !PWDATA[0]) begin
				ev_reg[g] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// transaction sequencer and memory channels
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= smd_pkg::SMD_IDLE;
			rx_ptr_w_reg <= 32'h00000000;
			tx_ptr_w_reg <= 32'h00000000;
			rx_lim_w_reg <= '0;
			tx_lim_w_reg <= '0;
			rx_cnt_reg <= '0;
			tx_cnt_reg <= '0;
			tx_byte_reg <= 8'h00;
			shift_start_reg <= 1'b0;
			MEM_REQ <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_ADDR <= 32'h00000000;
			MEM_WDATA <= 8'h00;
		end else begin
			shift_start_reg <= 1'b0;
			unique case (state_reg)
				smd_pkg::SMD_IDLE: begin
					if (start_go) begin // see [RL3]
						// working copies let software prepare the next transfer
						rx_ptr_w_reg <= rx_ptr_reg; // see [RL15]
						tx_ptr_w_reg <= tx_ptr_reg;
						rx_lim_w_reg <= rx_lim_reg;
						tx_lim_w_reg <= tx_lim_reg;
						rx_cnt_reg <= '0;
						tx_cnt_reg <= '0;
						state_reg <= smd_pkg::SMD_CHECK;
					end
				end
				smd_pkg::SMD_CHECK: begin
					if (stop_pend_reg || (tx_reached && rx_reached)) begin
						state_reg <= smd_pkg::SMD_IDLE; // see [RL16]
					end else if (!tx_reached) begin
						MEM_REQ <= 1'b1; // see [RL14]
						MEM_WE <= 1'b0;
						MEM_ADDR <= tx_ptr_w_reg + 32'(tx_cnt_reg);
						state_reg <= smd_pkg::SMD_READ;
					end else begin
						tx_byte_reg <= fill_reg; // see [RL17]
						shift_start_reg <= 1'b1;
						state_reg <= smd_pkg::SMD_SHIFT;
					end
				end
				smd_pkg::SMD_READ: begin
					if (MEM_ACK) begin
						MEM_REQ <= 1'b0;
						tx_byte_reg <= MEM_RDATA;
						shift_start_reg <= 1'b1;
						state_reg <= smd_pkg::SMD_SHIFT;
					end
				end
				smd_pkg::SMD_SHIFT: begin
					if (shf_done) begin
						if (!tx_reached) begin
							tx_cnt_reg <= tx_cnt_reg + 1'b1;
						end
						if (!rx_reached) begin
							MEM_REQ <= 1'b1; // see [RL14]
							MEM_WE <= 1'b1;
							MEM_ADDR <= rx_ptr_w_reg + 32'(rx_cnt_reg);
							MEM_WDATA <= shf_rx;
							state_reg <= smd_pkg::SMD_STORE;
						end else begin
							state_reg <= smd_pkg::SMD_CHECK; // see [RL18]
						end
					end
				end
				smd_pkg::SMD_STORE: begin
					if (MEM_ACK) begin
						MEM_REQ <= 1'b0;
						MEM_WE <= 1'b0;
						rx_cnt_reg <= rx_cnt_reg + 1'b1;
						state_reg <= smd_pkg::SMD_CHECK;
					end
				end
			endcase
		end
	end

	// stop is honoured at a byte boundary, never in the middle of a memory access
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			stop_pend_reg <= 1'b0;
			tx_flag_reg <= 1'b0;
			rx_flag_reg <= 1'b0;
			both_flag_reg <= 1'b0;
		end else if (start_go) begin
			stop_pend_reg <= 1'b0;
			tx_flag_reg <= 1'b0;
			rx_flag_reg <= 1'b0;
			both_flag_reg <= 1'b0;
		end else begin
			if (halting) begin
				stop_pend_reg <= 1'b0;
			end else if (stop_go && state_reg != smd_pkg::SMD_IDLE) begin
				stop_pend_reg <= 1'b1; // see [RL7]
			end
			if (tx_raise) tx_flag_reg <= 1'b1;
			if (rx_raise) rx_flag_reg <= 1'b1;
			if (both_raise) both_flag_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// serial pins
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			miso_s1_reg <= 1'b0;
			miso_s2_reg <= 1'b0;
		end else begin
			miso_s1_reg <= MISO_IN;
			miso_s2_reg <= miso_s1_reg;
		end
	end

	smd_byte_shifter #(
		.DIV_W(DIV_W)
	) u_shifter (
		.sys_clk(SYS_CLK),
		.nrst(NRST),
		.start(shift_start_reg),
		.cpol(config_reg[`SMD_CFG_POL_BIT]),
		.cpha(config_reg[`SMD_CFG_PHASE_BIT]),
		.lsb_first(config_reg[`SMD_CFG_ORDER_BIT]),
		.half_cycles(half_reg),
		.tx_byte(tx_byte_reg),
		.miso_sync(miso_s2_reg && enable_reg && !pin_din_reg[`SMD_PIN_CONNECT_BIT]),
		.sck(shf_sck),
		.mosi(shf_mosi),
		.busy(shf_busy),
		.done(shf_done),
		.rx_byte(shf_rx)
	);

	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			SCK_OUT <= 1'b0;
			MOSI_OUT <= 1'b0;
			SCK_OE <= 1'b0;
			MOSI_OE <= 1'b0;
		end else begin
			SCK_OUT <= shf_sck;
			MOSI_OUT <= shf_mosi;
			SCK_OE <= enable_reg && !pin_clk_reg[`SMD_PIN_CONNECT_BIT]; // see [RL11]
			MOSI_OE <= enable_reg && !pin_dout_reg[`SMD_PIN_CONNECT_BIT];
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	sequence s_fill_pick;
		in_check && !stop_pend_reg && tx_reached && !rx_reached;
	endsequence
	sequence s_fill_loaded;
		shift_start_reg && tx_byte_reg == $past(fill_reg);
	endsequence

	AST_START_BEGAN: assert property (start_go |=> ev_reg[`SMD_EV_BEGAN] && state_reg == smd_pkg::SMD_CHECK) // see [RL3]
		else $error("start did not raise began");
	AST_TX_DONE_COUNT: assert property (tx_raise && !stop_pend_reg |-> tx_cnt_reg == tx_lim_w_reg) // see [RL4]
		else $error("tx done at wrong count");
	AST_RX_DONE_COUNT: assert property (rx_raise && !stop_pend_reg |-> rx_cnt_reg == rx_lim_w_reg) // see [RL5]
		else $error("rx done at wrong count");
	AST_BOTH_AFTER_EACH: assert property (both_raise |=> tx_flag_reg && rx_flag_reg && ev_reg[`SMD_EV_BOTH_DONE]) // see [RL6]
		else $error("both done without both events");
	AST_HALTED_AT_REST: assert property (halting |=> state_reg == smd_pkg::SMD_IDLE && !shf_busy && !MEM_REQ) // see [RL7]
		else $error("halted while still active");
	AST_HALT_FORCES_DONES: assert property (halting |=> tx_flag_reg && rx_flag_reg && ev_reg[`SMD_EV_RX_DONE]) // see [RL8] [RL9]
		else $error("halt left a done event unraised");
	AST_FILL_BYTE: assert property (s_fill_pick |=> s_fill_loaded ##1 shf_busy) // see [RL17]
		else $error("fill byte not sent");
	AST_DROP_EXTRA: assert property (shf_done && rx_reached |=> !MEM_REQ && state_reg == smd_pkg::SMD_CHECK) // see [RL18]
		else $error("extra rx byte written");
	AST_SHADOW_HELD: assert property (state_reg != smd_pkg::SMD_IDLE && $past(state_reg) != smd_pkg::SMD_IDLE
		|-> $stable(tx_lim_w_reg) && $stable(rx_ptr_w_reg)) // see [RL15]
		else $error("working copy changed mid transfer");
	AST_CLK_IDLE: assert property (!shf_busy && $past(!shf_busy) |=> SCK_OUT == $past(config_reg[`SMD_CFG_POL_BIT], 2)) // see [RL1]
		else $error("clock pin not at idle level");
endmodule // smd_spi_master_dma

/* verif/smd_slave_model.sv */
`timescale 1ns/10ps
module smd_slave_model #(
	parameter logic [7:0] REPLY_BASE = 8'h3C
) (
	input wire logic nrst,
	input wire logic sck,
	input wire logic mosi,
	input wire logic cpol,
	input wire logic cpha,
	output logic miso,
	output logic [7:0] last_rx,
	output logic [7:0] nbytes
);
	// ----------------------------------------
	// slave shift logic, msb first
	// ----------------------------------------
	logic [7:0] tx_sr;
	logic [7:0] rx_sr;
	logic [3:0] n;
	assign miso = tx_sr[7];
	// no select line here: software selects the slave through a general-purpose pin
	// mode decides which clock edge samples and which shifts
	always @(sck, negedge nrst) begin
		if (!nrst) begin
			tx_sr = REPLY_BASE;
			n = 4'h0;
			nbytes = 8'h00;
			last_rx = 8'h00;
		end else if ((sck != cpol) != cpha) begin
			rx_sr = {rx_sr[6:0], mosi};
			n = n + 4'h1;
			if (n == 4'h8) begin
				last_rx = rx_sr;
				nbytes = nbytes + 8'h01;
				if (cpha) begin
					tx_sr = REPLY_BASE + nbytes;
					n = 4'h0;
				end
			end
		end else if (n == 4'h8) begin
			tx_sr = REPLY_BASE + nbytes;
			n = 4'h0;
		end else if (!cpha || n != 4'h0) begin
			tx_sr = tx_sr << 1;
		end
	end
endmodule // smd_slave_model

/* verif/smd_spi_master_dma_tb.sv */
`timescale 1ns/10ps
`include "smd_consts.svh"
module smd_spi_master_dma_tb;
	// ----------------------------------------
	// signals, models
	// ----------------------------------------
	typedef struct packed {logic [2:0] cfg; logic [7:0] ntx; logic [7:0] nrx; logic [7:0] fill; logic [7:0] nb;} smd_row_t;
	smd_row_t rows [4] = '{'{3'h0, 8'h02, 8'h02, 8'h00, 8'h02}, '{3'h3, 8'h01, 8'h03, 8'h5A, 8'h03},
		'{3'h4, 8'h03, 8'h01, 8'h00, 8'h03}, '{3'h6, 8'h02, 8'h00, 8'h00, 8'h02}};
	logic sys_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, mem_ack = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, mem_addr, rd;
	logic pready, pslverr, mem_req, mem_we, sck, sck_oe, mosi, mosi_oe, miso, err;
	logic sl_nrst = 1'h0, cpol = 1'h0, cpha = 1'h0;
	logic [7:0] mem_wdata, mem_rdata = 8'h00, sl_last, sl_cnt, e;
	logic [7:0] mem [256];
	logic [7:0] log_q [256];
	logic [11:0] ev [5] = '{`SMD_OFS_EV_HALTED, `SMD_OFS_EV_RX_DONE, `SMD_OFS_EV_BOTH_DONE, `SMD_OFS_EV_TX_DONE,
		`SMD_OFS_EV_BEGAN};
	int failures = 0;
	int total_checks = 0;
	smd_spi_master_dma uut (.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MEM_REQ(mem_req),
		.MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
		.SCK_OUT(sck), .SCK_OE(sck_oe), .MOSI_OUT(mosi), .MOSI_OE(mosi_oe), .MISO_IN(miso));
	smd_slave_model sl (.nrst(sl_nrst), .sck(sck), .mosi(mosi), .cpol(cpol), .cpha(cpha), .miso(miso),
		.last_rx(sl_last), .nbytes(sl_cnt));
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		mem_ack <= mem_req && !mem_ack;
		mem_rdata <= mem[mem_addr[7:0]];
		if (mem_req && mem_ack && mem_we) begin
			mem[mem_addr[7:0]] <= mem_wdata;
		end
	end
	always @(sl_cnt) begin
		if (sl_cnt != 8'h00) begin
			log_q[sl_cnt - 8'h01] = sl_last;
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		total_checks++;
		if (g !== x) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) cmp(32'h0, 32'h1);
	endtask
	task automatic ck(input logic [11:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		cmp(rd, x);
	endtask
	task automatic poll(input logic [11:0] a);
		int n;
		n = 0;
		do begin
			apb(1'h0, a, 32'h0);
			n++;
		end while (rd !== 32'h1 && n < 500);
		// a flag that never comes counts as a mismatch
		cmp(rd, 32'h1);
	endtask
	task automatic run(input smd_row_t r);
		sl_nrst <= 1'h0;
		cpol <= r.cfg[2];
		cpha <= r.cfg[1];
		for (int k = 0; k < 8; k++) mem[8'h80 + k] = 8'hEE;
		apb(1'h1, `SMD_OFS_CONFIG, {29'h0, r.cfg});
		apb(1'h1, `SMD_OFS_TX_POINTER, 32'h40);
		apb(1'h1, `SMD_OFS_TX_LIMIT, {24'h0, r.ntx});
		apb(1'h1, `SMD_OFS_RX_POINTER, 32'h80);
		apb(1'h1, `SMD_OFS_RX_LIMIT, {24'h0, r.nrx});
		apb(1'h1, `SMD_OFS_FILL, {24'h0, r.fill});
		foreach (ev[k]) apb(1'h1, ev[k], 32'h0);
		sl_nrst <= 1'h1;
		apb(1'h1, `SMD_OFS_TASK_START, 32'h1);
		ck(`SMD_OFS_EV_BEGAN, 32'h1);
	endtask
	task automatic print_verdict;
		if (failures == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		print_verdict;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
		repeat (16) @(posedge sys_clk);
		nrst <= 1'h1;
		// pins routed once, before enabling, all three selects to pin 0
		for (int k = 0; k < 3; k++) apb(1'h1, `SMD_OFS_PIN_CLK + 12'h4 * k[11:0], 32'h0);
		apb(1'h1, `SMD_OFS_ENABLE, 32'h1);
		apb(1'h1, `SMD_OFS_RATE, 32'h80000000);
		cmp({sck_oe, mosi_oe}, 2'h3);
		foreach (rows[i]) begin
			run(rows[i]);
			poll(`SMD_OFS_EV_BOTH_DONE);
			ck(`SMD_OFS_EV_TX_DONE, 32'h1);
			ck(`SMD_OFS_EV_RX_DONE, 32'h1);
			ck(`SMD_OFS_EV_HALTED, 32'h0);
			ck(`SMD_OFS_TX_AMOUNT, {24'h0, rows[i].ntx});
			cmp(sl_cnt, rows[i].nb);
			for (int k = 0; k < rows[i].nb; k++) begin
				e = (k < rows[i].ntx) ? ~(8'h40 + k[7:0]) : rows[i].fill;
				if (rows[i].cfg[0]) e = {<<{e}};
				cmp(e, log_q[k]);
			end
			for (int k = 0; k <= rows[i].nrx; k++) begin
				e = (k < rows[i].nrx) ? 8'h3C + k[7:0] : 8'hEE;
				if (rows[i].cfg[0] && k < rows[i].nrx) e = {<<{e}};
				cmp(mem[8'h80 + k], e);
			end
		end
		apb(1'h1, `SMD_OFS_PIN_CLK, 32'h8000001F);
		ck(`SMD_OFS_PIN_CLK, 32'h0);
		run('{3'h0, 8'h05, 8'h05, 8'h00, 8'h05});
		repeat (300) @(posedge sys_clk);
		apb(1'h1, `SMD_OFS_TASK_STOP, 32'h1);
		poll(`SMD_OFS_EV_HALTED);
		ck(`SMD_OFS_EV_TX_DONE, 32'h1);
		ck(`SMD_OFS_EV_RX_DONE, 32'h1);
		cmp(sl_cnt < 8'h05, 1'h1);
		apb(1'h1, `SMD_OFS_ENABLE, 32'h0);
		ck(`SMD_OFS_ENABLE, 32'h0);
		ck(12'hFFC, 32'h0);
		cmp(err, 1'h1);
		nrst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		cmp(sck, 1'h0);
		nrst <= 1'h1;
		ck(`SMD_OFS_RATE, `SMD_RST_RATE);
		ck(`SMD_OFS_PIN_CLK, `SMD_RST_PIN);
		ck(`SMD_OFS_ENABLE, 32'h0);
		print_verdict;
	end
endmodule // smd_spi_master_dma_tb
